// ==== design/qpf_pkg.sv ====
`default_nettype none
package qpf_pkg;
  localparam int unsigned NUM_PORTS = 4;
  // Time base: one tick per 0.8 ms at 20 MHz
  localparam real CLK_MHZ = 20.0;
  localparam real TICK_US = 800.0;
  localparam int unsigned TICK_CYC = int'(TICK_US * CLK_MHZ);
  // Delays as printed, then in ticks
  localparam real RELAY_ON_MS = 25.6;
  localparam real RELAY_OFF_MS = 3.2;
  localparam real OPEN_DLY_MS = 25.6;
  localparam real OPEN_ARM_MS = 900.0;
  localparam real WIN_STEP_MS = 6.4;
  localparam logic [15:0] RELAY_ON_TK = 16'(int'(RELAY_ON_MS * 1000.0 / TICK_US));
  localparam logic [15:0] RELAY_OFF_TK = 16'(int'(RELAY_OFF_MS * 1000.0 / TICK_US));
  localparam logic [15:0] OPEN_DLY_TK = 16'(int'(OPEN_DLY_MS * 1000.0 / TICK_US));
  localparam logic [15:0] OPEN_ARM_TK = 16'(int'(OPEN_ARM_MS * 1000.0 / TICK_US));
  localparam logic [15:0] WIN_STEP_TK = 16'(int'(WIN_STEP_MS * 1000.0 / TICK_US));
  // Window setting 1..20 gives 6.4 ms .. 128 ms
  localparam logic [4:0] WIN_SET_MIN = 5'h01;
  localparam logic [4:0] WIN_SET_MAX = 5'h14;
  // Retry off-time in windows
  localparam logic [6:0] RETRY_LOW = 7'h63;
  localparam logic [6:0] RETRY_HIGH = 7'h31;
  localparam logic [6:0] RETRY_OPEN = 7'h18;
  // Three-level duty selector
  typedef enum logic [1:0] {DUTY_LOW = 2'h0, DUTY_HIGH = 2'h1, DUTY_OPEN = 2'h2} qpf_duty_e;
  // Per-port sensed conditions from the analog side
  typedef struct packed {
    logic in_limit;
    logic vds_low;
    logic cur_low;
  } qpf_sense_s;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_WAIT = 5'h02,
    ST_ON = 5'h04,
    ST_LATCH = 5'h08,
    ST_RETRY = 5'h10
  } qpf_state_e;
endpackage
`default_nettype wire

// ==== design/qpf_ctrl.sv ====
`default_nettype none
module qpf_ctrl #(
  parameter int unsigned TICK_CYCLES = qpf_pkg::TICK_CYC
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SUPPLY_LOCKOUT_I,
  input wire logic [3:0] SWITCH_REQ_I,
  input wire logic [3:0] RELAY_REQUEST_I,
  input wire logic STATUS_VIEW_SELECT_I,
  input wire logic OPEN_DETECT_ENABLE_I,
  input wire logic AUTO_RETRY_ENABLE_I,
  input wire qpf_pkg::qpf_duty_e RETRY_DUTY_SELECT_I,
  input wire logic [4:0] TIMEBASE_SET_PIN_I,
  input wire qpf_pkg::qpf_sense_s [3:0] SENSE_I,
  output logic [3:0] SWITCH_EN_O,
  output logic [3:0] RELAY_DRIVER_OUT_O,
  output logic [3:0] STATUS_O,
  output logic FAULT_N_O
);
  import qpf_pkg::*;

  // Two-stage synchronisers for every pin input except SYS_RST_I
  localparam int unsigned SW = 4 + 4 + 1 + 1 + 1 + 2 + 5 + 12 + 1;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  assign pin_raw = {SWITCH_REQ_I, RELAY_REQUEST_I, STATUS_VIEW_SELECT_I, OPEN_DETECT_ENABLE_I,
                    AUTO_RETRY_ENABLE_I, RETRY_DUTY_SELECT_I, TIMEBASE_SET_PIN_I, SENSE_I, SUPPLY_LOCKOUT_I};
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync1_q <= '0;
      sync2_q <= {{(SW-1){1'b0}}, 1'b1};
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [3:0] sw_req;
  logic [3:0] rly_req;
  logic view_sel;
  logic open_en;
  logic retry_en;
  logic [1:0] duty;
  logic [4:0] win_set;
  qpf_sense_s [3:0] sense;
  logic lockout;
  assign {sw_req, rly_req, view_sel, open_en, retry_en, duty, win_set, sense, lockout} = sync2_q;

  // Shared time-base tick; one tick per 0.8 ms
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // Window in ticks, clamped to the legal range
  logic [4:0] win_clamp;
  logic [15:0] win_tk;
  logic [6:0] retry_n;
  always_comb begin
    win_clamp = win_set;
    if (win_set < WIN_SET_MIN) win_clamp = WIN_SET_MIN;
    if (win_set > WIN_SET_MAX) win_clamp = WIN_SET_MAX;
    win_tk = 16'(win_clamp * WIN_STEP_TK);
    unique case (duty)
      DUTY_LOW: retry_n = RETRY_LOW;
      DUTY_HIGH: retry_n = RETRY_HIGH;
      default: retry_n = RETRY_OPEN;
    endcase
  end

  logic [3:0] latched;
  logic [3:0] open_flag;
  logic [3:0] pgood;

  genvar p;
  for (p = 0; p < NUM_PORTS; p++) begin : g_port
    qpf_state_e st_q;
    logic [15:0] cnt_q;    // ticks in the current window
    logic [6:0] win_n_q;   // windows elapsed in retry off-time
    logic [15:0] rly_cnt_q;
    logic rly_q;
    logic rly_ready_q;
    logic rly_req_d1_q;
    logic open_q;
    logic [15:0] arm_q;
    logic [15:0] low_q;
    logic [15:0] lim_q;
    logic pg;

    // Relay: on at once, switch held 25.6 ms; off 3.2 ms after the switch
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || lockout) begin
        rly_q <= 1'b0;
        rly_ready_q <= 1'b0;
        rly_cnt_q <= '0;
        rly_req_d1_q <= 1'b0;
      end else begin
        rly_req_d1_q <= rly_req[p];
        if (rly_req[p] && !rly_req_d1_q) begin
          rly_q <= 1'b1;
          rly_ready_q <= 1'b0;
          rly_cnt_q <= '0;
        end else if (!rly_req[p] && rly_req_d1_q) begin
          rly_ready_q <= 1'b0;
          rly_cnt_q <= '0;
        end else if (tick && rly_q) begin
          if (rly_req[p] && !rly_ready_q) begin
            rly_cnt_q <= rly_cnt_q + 16'h0001;
            if (rly_cnt_q + 16'h0001 >= RELAY_ON_TK) rly_ready_q <= 1'b1;
          end else if (!rly_req[p]) begin
            rly_cnt_q <= rly_cnt_q + 16'h0001;
            if (rly_cnt_q + 16'h0001 >= RELAY_OFF_TK) rly_q <= 1'b0;
          end
        end
      end
    end

    // Power-good: drop small, not limiting, not open
    assign pg = (st_q == ST_ON) && sense[p].vds_low && !sense[p].in_limit && !open_q;

    // Port state machine
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I || lockout) begin
        st_q <= ST_OFF;
        cnt_q <= '0;
        win_n_q <= '0;
        open_q <= 1'b0;
        arm_q <= '0;
        low_q <= '0;
        lim_q <= '0;
      end else begin
        unique case (st_q)
          ST_OFF: begin
            // Off-time guard even on the first request after a clear
            if (sw_req[p]) begin
              st_q <= ST_WAIT;
              cnt_q <= '0;
              win_n_q <= '0;
            end
          end
          ST_LATCH: begin
            if (!sw_req[p]) begin
              st_q <= ST_RETRY;
              open_q <= 1'b0;
              cnt_q <= '0;
              win_n_q <= '0;
            end
          end
          ST_WAIT, ST_RETRY: begin
            if (tick) begin
              if (cnt_q + 16'h0001 >= win_tk) begin
                cnt_q <= '0;
                if (win_n_q != retry_n) win_n_q <= win_n_q + 7'h01;
              end else begin
                cnt_q <= cnt_q + 16'h0001;
              end
            end
            // Retry waits for its own timer; a cleared latch also needs the request
            if (win_n_q >= retry_n && (st_q == ST_WAIT || sw_req[p]) && rly_ready_q && rly_req[p]) begin
              st_q <= ST_ON;
              arm_q <= '0;
              low_q <= '0;
              lim_q <= '0;
            end else if (st_q == ST_WAIT && !sw_req[p]) begin
              st_q <= ST_OFF;
            end
          end
          ST_ON: begin
            if (!sw_req[p] || !rly_req[p] || !rly_ready_q) begin
              st_q <= ST_OFF;
            end else if (tick) begin
              lim_q <= sense[p].in_limit ? lim_q + 16'h0001 : '0;
              if (sense[p].in_limit && lim_q + 16'h0001 >= win_tk) begin
                // Overcurrent: retry or hold latched
                st_q <= retry_en ? ST_RETRY : ST_LATCH;
                cnt_q <= '0;
                win_n_q <= '0;
              end
              if (pg && arm_q != OPEN_ARM_TK) arm_q <= arm_q + 16'h0001;
              if (open_en && arm_q == OPEN_ARM_TK && sense[p].cur_low) begin
                low_q <= low_q + 16'h0001;
                if (low_q + 16'h0001 >= OPEN_DLY_TK) begin
                  st_q <= ST_LATCH;
                  open_q <= 1'b1;
                end
              end else begin
                low_q <= '0;
              end
            end
          end
          default: st_q <= ST_OFF;
        endcase
      end
    end

    assign SWITCH_EN_O[p] = (st_q == ST_ON) && rly_q && !lockout;
    assign RELAY_DRIVER_OUT_O[p] = rly_q;
    assign latched[p] = (st_q == ST_LATCH);
    assign open_flag[p] = open_q && open_en;
    assign pgood[p] = pg;
  end

  // Status mux and shared fault, registered
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      STATUS_O <= 4'h0;
      FAULT_N_O <= 1'b0;
    end else begin
      STATUS_O <= view_sel ? pgood : open_flag;
      FAULT_N_O <= !(lockout || (|latched));
    end
  end

  a_lockout_off: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    lockout |=> (SWITCH_EN_O == 4'h0) && (RELAY_DRIVER_OUT_O == 4'h0))
    else $error("Outputs not off under lockout");
  a_fault_latch: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (|latched) |=> !FAULT_N_O)
    else $error("Fault not asserted for latched port");
  a_status_pg: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    view_sel |=> STATUS_O == $past(pgood))
    else $error("Status does not show power-good");
  a_status_open: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    !view_sel |=> STATUS_O == $past(open_flag))
    else $error("Status does not show open flag");
  a_open_dis: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (!open_en && !view_sel) |=> STATUS_O == 4'h0)
    else $error("Open view high with detection off");
  a_sw_needs_relay: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    SWITCH_EN_O[0] |-> RELAY_DRIVER_OUT_O[0])
    else $error("Switch on without relay");
  a_relay_rise: assert property (@(posedge CLK_I) disable iff (SYS_RST_I || lockout)
    $rose(rly_req[0]) |=> RELAY_DRIVER_OUT_O[0] && !SWITCH_EN_O[0])
    else $error("Relay not energised at once");
  a_relay_fall: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $fell(rly_req[0]) |=> ##1 !SWITCH_EN_O[0])
    else $error("Switch not dropped on relay fall");
  a_pg_limit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    sense[0].in_limit |-> !pgood[0])
    else $error("Power-good during current limit");
endmodule
`default_nettype wire

// ==== tb/qpf_load_model.sv ====
`default_nettype none
// External switches and loads: 0 normal, 1 short, 2 open per port
module qpf_load_model
  import qpf_pkg::*;
(
  input wire logic [3:0] sw_en_i,
  input wire logic [7:0] mode_i,
  output qpf_sense_s [3:0] sense_o
);
  // An off switch carries no current, so the open sense reads low current then
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      sense_o[p].in_limit = sw_en_i[p] && (mode_i[2*p +: 2] == 2'h1);
      sense_o[p].vds_low = sw_en_i[p] && (mode_i[2*p +: 2] != 2'h1);
      sense_o[p].cur_low = !sw_en_i[p] || (mode_i[2*p +: 2] == 2'h2);
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import qpf_pkg::*;
  localparam int TK = 4;
  localparam int WIN = WIN_STEP_TK * TK;
  localparam int SL = 3 * TK + 8;
  typedef struct {qpf_duty_e d; int w;} row_s;
  row_s rows [3] = '{'{DUTY_LOW, RETRY_LOW}, '{DUTY_HIGH, RETRY_HIGH}, '{DUTY_OPEN, RETRY_OPEN}};
  logic clk = 0, rst = 1, lock = 0, view = 1, oden = 0, rtry = 0;
  logic [3:0] swr = '0, rlr = '0, sw_en, rly, stat;
  logic [7:0] mode = '0;
  logic [4:0] tbs = 5'h01;
  logic fault_n;
  qpf_duty_e duty = DUTY_LOW;
  qpf_sense_s [3:0] sense;
  int errors = 0, n_checks = 0, cyc = 0, n, off;
  qpf_ctrl #(.TICK_CYCLES(TK)) dut (.CLK_I(clk), .SYS_RST_I(rst), .SUPPLY_LOCKOUT_I(lock), .SWITCH_REQ_I(swr),
    .RELAY_REQUEST_I(rlr), .STATUS_VIEW_SELECT_I(view), .OPEN_DETECT_ENABLE_I(oden), .AUTO_RETRY_ENABLE_I(rtry),
    .RETRY_DUTY_SELECT_I(duty), .TIMEBASE_SET_PIN_I(tbs), .SENSE_I(sense), .SWITCH_EN_O(sw_en),
    .RELAY_DRIVER_OUT_O(rly), .STATUS_O(stat), .FAULT_N_O(fault_n));
  qpf_load_model load (.sw_en_i(sw_en), .mode_i(mode), .sense_o(sense));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %0t %s took %0d cycles", $time, what, got);
    end
  endtask
  // Bounded wait so a stuck switch ends in a mismatch rather than a hang
  task automatic wait_sw(input logic lvl, input int lim);
    n = 0;
    while (sw_en[0] !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Run ceiling well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      $display("[ERR] %0t run ceiling reached", $time);
      end_sim();
    end
  end
  initial begin
    cyc_n(16);
    cmp(fault_n, 1'b0, "fault in reset");
    cmp(rly[0], 1'b0, "relay in reset");
    @(posedge clk) rst <= 0;
    @(posedge clk) rlr <= 4'hf;
    cyc_n(6);
    cmp(rly[0], 1'b1, "relay rise");
    cmp(fault_n, 1'b1, "fault idle");
    cyc_n(32 * TK);
    foreach (rows[i]) begin
      off = rows[i].w * WIN;
      @(posedge clk) begin
        duty <= rows[i].d;
        swr[0] <= 1'b1;
      end
      #1 wait_sw(1'b1, off + SL);
      cmp_rng(n, off - SL, off + SL, "start wait");
      cyc_n(4);
      cmp(stat[0], 1'b1, "power good");
      @(posedge clk) view <= 1'b0;
      cyc_n(6);
      cmp(stat[0], 1'b0, "open view good");
      @(posedge clk) begin
        view <= 1'b1;
        swr[0] <= 1'b0;
      end
      #1 wait_sw(1'b0, 8);
      cmp(sw_en[0], 1'b0, "request off");
    end
    // Overcurrent with latch-off, duty open left from the last row
    @(posedge clk) swr[0] <= 1'b1;
    #1 wait_sw(1'b1, off + SL);
    // Window doubled by the time-base setting for this short only
    @(posedge clk) begin
      mode[1:0] <= 2'h1;
      tbs <= 5'h02;
    end
    #1 wait_sw(1'b0, 2 * WIN + SL);
    cmp_rng(n, 2 * WIN - SL, 2 * WIN + SL, "limit window");
    cyc_n(4);
    cmp(fault_n, 1'b0, "fault on latch");
    cmp(stat[0], 1'b0, "pg dropped");
    @(posedge clk) begin
      mode[1:0] <= 2'h0;
      tbs <= 5'h01;
    end
    cyc_n(off + WIN);
    cmp(sw_en[0], 1'b0, "stays latched");
    cmp(fault_n, 1'b0, "fault held");
    @(posedge clk) swr[0] <= 1'b0;
    cyc_n(6);
    cmp(fault_n, 1'b1, "latch cleared");
    // Auto-retry against a persistent short
    @(posedge clk) begin
      rtry <= 1'b1;
      mode[1:0] <= 2'h1;
      swr[0] <= 1'b1;
    end
    #1 wait_sw(1'b1, off + SL);
    wait_sw(1'b0, WIN + SL);
    wait_sw(1'b1, off + SL);
    cmp_rng(n, off - SL, off + SL, "retry off-time");
    @(posedge clk) mode[1:0] <= 2'h0;
    cyc_n(WIN + SL);
    cmp(sw_en[0], 1'b1, "retry recovered");
    // Open load with detection on
    @(posedge clk) begin
      rtry <= 1'b0;
      oden <= 1'b1;
      mode[1:0] <= 2'h2;
    end
    #1 wait_sw(1'b0, 1160 * TK + SL);
    cmp_rng(n, 32 * TK, 1157 * TK + SL, "open trip");
    @(posedge clk) view <= 1'b0;
    cyc_n(6);
    cmp(fault_n, 1'b0, "open fault");
    cmp(stat[0], 1'b1, "open flag");
    @(posedge clk) oden <= 1'b0;
    cyc_n(6);
    cmp(stat[0], 1'b0, "detect off view");
    @(posedge clk) begin
      swr[0] <= 1'b0;
      mode[1:0] <= 2'h0;
      view <= 1'b1;
    end
    cyc_n(6);
    cmp(fault_n, 1'b1, "open cleared");
    // Relay fall with the switch on
    @(posedge clk) swr[0] <= 1'b1;
    #1 wait_sw(1'b1, off + SL);
    @(posedge clk) rlr[0] <= 1'b0;
    #1 wait_sw(1'b0, 6);
    cmp_rng(n, 0, 5, "switch drop");
    cyc_n(2 * TK);
    cmp(rly[0], 1'b1, "relay delay");
    cyc_n(2 * TK + SL);
    cmp(rly[0], 1'b0, "relay off");
    @(posedge clk) lock <= 1'b1;
    cyc_n(6);
    cmp(fault_n, 1'b0, "lockout fault");
    cmp(rly[1], 1'b0, "lockout relay");
    end_sim();
  end
endmodule
`default_nettype wire
